/* src/fqh_ctrl.sv */
// Host controller that drives an asynchronous parallel flash through its strobes,
// enters and leaves the query mode and checks the query words it reads back.
// Assumes pins are joined outside; supply, ready and data inputs are asynchronous.
`timescale 1ns/10ps
`include "fqh_map.svh"

// Summary of operation
// - Output enable low, or chip or write enable high, blocks any write.
// - Host writes with chip and write enable low, output enable high.
// - Query command 98h at word address 55h enters query mode.
// - Query mode lasts until the reset command or a supply drop returns to array reads.
module fqh_ctrl
(
    input  wire logic                    i_clk,
    input  wire logic                    i_resetn,
    input  wire logic                    i_supply_ok,
    input  wire logic                    i_dev_ready,
    input  wire logic                    i_byte_mode,
    input  wire logic                    i_req_valid,
    input  wire fqh_pkg::fqh_op_t        i_req_op,
    input  wire logic [`FQH_ADDR_W-1:0]  i_req_addr,
    input  wire logic [`FQH_DATA_W-1:0]  i_req_data,
    input  wire logic [`FQH_DATA_W-1:0]  i_dq_in,
    output logic                         o_req_ready,
    output logic                         o_rd_valid,
    output logic      [`FQH_DATA_W-1:0]  o_rd_data,
    output logic                         o_refused,
    output logic                         o_in_query,
    output logic                         o_cfi_mismatch,
    output logic                         o_ce_n,
    output logic                         o_oe_n,
    output logic                         o_we_n,
    output logic                         o_byte_n,
    output logic      [`FQH_ADDR_W-1:0]  o_addr,
    output logic      [`FQH_DATA_W-1:0]  o_dq_out,
    output logic                         o_dq_oe
);

    // Expected query word for a word index; bit 16 says the index is checked
    function automatic logic [16:0] cfi_expect(input logic [7:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        case (idx)
            8'h10: v = 16'h0051;
            8'h11: v = 16'h0052;
            8'h12: v = 16'h0059;
            8'h13: v = 16'h0002;
            8'h15: v = 16'h0040;
            8'h1b: v = 16'h0027;
            8'h1c: v = 16'h0036;
            8'h1f: v = 16'h0007;
            8'h20: v = 16'h0007;
            8'h21: v = 16'h000a;
            8'h23: v = 16'h0001;
            8'h24: v = 16'h0005;
            8'h25: v = 16'h0004;
            8'h27: v = 16'h0016;
            8'h28: v = 16'h0002;
            8'h2a: v = 16'h0005;
            8'h2c: v = 16'h0001;
            8'h2d: v = 16'h003f;
            8'h30: v = 16'h0001;
            8'h40: v = 16'h0050;
            8'h41: v = 16'h0052;
            8'h42: v = 16'h0049;
            default: v = 16'h0000;
        endcase
        cfi_expect = {((idx >= `FQH_QRY_FIRST) && (idx <= `FQH_QRY_LAST))
                      || ((idx >= `FQH_PRI_FIRST) && (idx <= `FQH_PRI_LAST)), v};
    endfunction

    // Pin address for a word index; byte mode doubles it
    function automatic logic [`FQH_ADDR_W-1:0] pin_addr(input logic [`FQH_ADDR_W-1:0] w, input logic bm);
        pin_addr = bm ? {w[`FQH_ADDR_W-2:0], 1'b0} : w;
    endfunction

    // Word index of a pin address, low 8 bits only
    function automatic logic [7:0] word_idx(input logic [`FQH_ADDR_W-1:0] a, input logic bm);
        word_idx = bm ? a[8:1] : a[7:0];
    endfunction

    logic [1:0]               rst_sync_ff;
    logic                     rstn;
    logic [`FQH_SYNC_W-1:0]   pins_s;
    logic                     supply_s;
    logic                     ready_s;
    logic [`FQH_DATA_W-1:0]   dq_s;

    fqh_pkg::fqh_state_t      state_ff;
    fqh_pkg::fqh_state_t      nxt_state;
    fqh_pkg::fqh_op_t         op_ff;
    fqh_pkg::fqh_op_t         nxt_op;
    logic [`FQH_CNT_W-1:0]    cnt_ff;
    logic [`FQH_CNT_W-1:0]    nxt_cnt;
    logic [`FQH_GUARD_W-1:0]  guard_ff;
    logic [`FQH_GUARD_W-1:0]  nxt_guard;
    logic                     req_ready_ff;
    logic                     rd_valid_ff;
    logic [`FQH_DATA_W-1:0]   rd_data_ff;
    logic                     refused_ff;
    logic                     in_query_ff;
    logic                     nxt_in_query;
    logic                     mismatch_ff;
    logic                     ce_n_ff;
    logic                     oe_n_ff;
    logic                     we_n_ff;
    logic                     byte_n_ff;
    logic [`FQH_ADDR_W-1:0]   addr_ff;
    logic [`FQH_ADDR_W-1:0]   nxt_addr;
    logic [`FQH_DATA_W-1:0]   dq_out_ff;
    logic [`FQH_DATA_W-1:0]   nxt_dq_out;
    logic                     dq_oe_ff;

    wire                      take;
    wire                      refuse;
    wire                      cnt_done;
    wire                      pwr_ok;
    wire                      rd_end;
    wire [16:0]               expect_w;

    // Reset asserts at once and releases through two flops
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            rst_sync_ff <= 2'h0;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rstn = rst_sync_ff[1];

    fqh_sync u_sync
    (
        .i_clk  (i_clk),
        .i_rstn (rstn),
        .i_d    ({i_supply_ok, i_dev_ready, i_dq_in}),
        .o_q    (pins_s)
    );
    assign supply_s = pins_s[17];
    assign ready_s  = pins_s[16];
    assign dq_s     = pins_s[15:0];

    // Guard lets the supply settle before the first strobe; no write starts in power-up
    assign pwr_ok   = supply_s && (guard_ff == `FQH_GUARD_W'(`FQH_PWR_GUARD_CYC));
    assign take     = (state_ff == fqh_pkg::FQH_ST_IDLE) && req_ready_ff && i_req_valid;
    assign refuse   = take && (i_req_op == fqh_pkg::FQH_OP_QUERY) && !ready_s;
    assign cnt_done = (cnt_ff == `FQH_CNT_W'(0));
    assign rd_end   = (state_ff == fqh_pkg::FQH_ST_RD) && cnt_done;
    assign expect_w = cfi_expect(word_idx(addr_ff, i_byte_mode));
    assign nxt_guard = !supply_s ? `FQH_GUARD_W'(0)
                     : (pwr_ok ? guard_ff : guard_ff + `FQH_GUARD_W'(1));

    // Sequencer: address set up first, strobes follow, data held past the rising edge
    always_comb
    begin
        nxt_state    = state_ff;
        nxt_op       = op_ff;
        nxt_cnt      = cnt_ff;
        nxt_addr     = addr_ff;
        nxt_dq_out   = dq_out_ff;
        nxt_in_query = in_query_ff;
        case (state_ff)
            fqh_pkg::FQH_ST_IDLE:
            begin
                if (take && !refuse)
                begin
                    nxt_op    = i_req_op;
                    nxt_state = fqh_pkg::FQH_ST_SETUP;
                    case (i_req_op)
                        fqh_pkg::FQH_OP_QUERY:
                        begin
                            nxt_addr   = pin_addr(`FQH_ADDR_QUERY, i_byte_mode);
                            nxt_dq_out = `FQH_CMD_QUERY;
                        end
                        fqh_pkg::FQH_OP_RESET:
                        begin
                            nxt_addr   = `FQH_ADDR_RESET;
                            nxt_dq_out = `FQH_CMD_RESET;
                        end
                        default:
                        begin
                            nxt_addr   = i_req_addr;
                            nxt_dq_out = i_req_data;
                        end
                    endcase
                end
            end
            fqh_pkg::FQH_ST_SETUP:
            begin
                if (op_ff == fqh_pkg::FQH_OP_READ)
                begin
                    nxt_state = fqh_pkg::FQH_ST_RD;
                    nxt_cnt   = `FQH_CNT_W'(`FQH_RD_CYC - 1);
                end
                else
                begin
                    nxt_state = fqh_pkg::FQH_ST_WR;
                    nxt_cnt   = `FQH_CNT_W'(`FQH_STB_CYC - 1);
                end
            end
            fqh_pkg::FQH_ST_WR:
            begin
                if (cnt_done)
                    nxt_state = fqh_pkg::FQH_ST_WHOLD;
                else
                    nxt_cnt = cnt_ff - `FQH_CNT_W'(1);
            end
            fqh_pkg::FQH_ST_WHOLD:
            begin
                nxt_state = fqh_pkg::FQH_ST_GAP;
                if (op_ff == fqh_pkg::FQH_OP_QUERY)
                    nxt_in_query = 1'b1;
                else if (op_ff == fqh_pkg::FQH_OP_RESET)
                    nxt_in_query = 1'b0;
            end
            fqh_pkg::FQH_ST_RD:
            begin
                if (cnt_done)
                    nxt_state = fqh_pkg::FQH_ST_GAP;
                else
                    nxt_cnt = cnt_ff - `FQH_CNT_W'(1);
            end
            default:
                nxt_state = fqh_pkg::FQH_ST_IDLE;
        endcase
        if (!supply_s)
        begin
            // Flash drops to array read on a low supply, so the host forgets query mode
            nxt_state    = fqh_pkg::FQH_ST_IDLE;
            nxt_in_query = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff     <= fqh_pkg::FQH_ST_IDLE;
            op_ff        <= fqh_pkg::FQH_OP_READ;
            cnt_ff       <= '0;
            guard_ff     <= '0;
            addr_ff      <= '0;
            dq_out_ff    <= '0;
            in_query_ff  <= 1'b0;
            req_ready_ff <= 1'b0;
            refused_ff   <= 1'b0;
        end
        else
        begin
            state_ff     <= nxt_state;
            op_ff        <= nxt_op;
            cnt_ff       <= nxt_cnt;
            guard_ff     <= nxt_guard;
            addr_ff      <= nxt_addr;
            dq_out_ff    <= nxt_dq_out;
            in_query_ff  <= nxt_in_query;
            req_ready_ff <= pwr_ok && (nxt_state == fqh_pkg::FQH_ST_IDLE) && !take;
            refused_ff   <= refuse;
        end
    end

    // Strobes: writes keep output enable high, reads keep write enable high
    always_ff @(posedge i_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ce_n_ff  <= 1'b1;
            oe_n_ff  <= 1'b1;
            we_n_ff  <= 1'b1;
            dq_oe_ff <= 1'b0;
            byte_n_ff <= 1'b1;
        end
        else
        begin
            ce_n_ff   <= !((nxt_state == fqh_pkg::FQH_ST_WR) || (nxt_state == fqh_pkg::FQH_ST_RD));
            we_n_ff   <= !(nxt_state == fqh_pkg::FQH_ST_WR);
            oe_n_ff   <= !(nxt_state == fqh_pkg::FQH_ST_RD);
            dq_oe_ff  <= (nxt_op != fqh_pkg::FQH_OP_READ)
                         && ((nxt_state == fqh_pkg::FQH_ST_SETUP) || (nxt_state == fqh_pkg::FQH_ST_WR)
                         || (nxt_state == fqh_pkg::FQH_ST_WHOLD));
            byte_n_ff <= !i_byte_mode;
        end
    end

    // Read capture; data path already passed two flops, counted into the read time
    always_ff @(posedge i_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_valid_ff <= 1'b0;
            rd_data_ff  <= '0;
            mismatch_ff <= 1'b0;
        end
        else
        begin
            rd_valid_ff <= rd_end;
            if (rd_end)
                rd_data_ff <= dq_s;
            if (rd_end && in_query_ff && expect_w[16] && (dq_s != expect_w[15:0]))
                mismatch_ff <= 1'b1;
            else if (take && (i_req_op == fqh_pkg::FQH_OP_QUERY))
                mismatch_ff <= 1'b0;
        end
    end

    assign o_req_ready    = req_ready_ff;
    assign o_rd_valid     = rd_valid_ff;
    assign o_rd_data      = rd_data_ff;
    assign o_refused      = refused_ff;
    assign o_in_query     = in_query_ff;
    assign o_cfi_mismatch = mismatch_ff;
    assign o_ce_n         = ce_n_ff;
    assign o_oe_n         = oe_n_ff;
    assign o_we_n         = we_n_ff;
    assign o_byte_n       = byte_n_ff;
    assign o_addr         = addr_ff;
    assign o_dq_out       = dq_out_ff;
    assign o_dq_oe        = dq_oe_ff;

endmodule

/* src/fqh_map.svh */
// Constants for the parallel flash query host: command values, command addresses,
// query table indices and strobe timing counts.
// Assumes a 200 MHz i_clk and an asynchronous x16/x8 flash on the far side.
`ifndef FQH_MAP_SVH
`define FQH_MAP_SVH

`define FQH_ADDR_W        22
`define FQH_DATA_W        16
`define FQH_SYNC_W        18

// Command words and their word addresses
`define FQH_CMD_QUERY     16'h0098
`define FQH_CMD_RESET     16'h00f0
`define FQH_ADDR_QUERY    22'h000055
`define FQH_ADDR_RESET    22'h000000

// Query table bounds, word indices
`define FQH_QRY_FIRST     8'h10
`define FQH_QRY_LAST      8'h3c
`define FQH_PRI_FIRST     8'h40
`define FQH_PRI_LAST      8'h42

// Timing, times in ns, counts in i_clk cycles
`define FQH_CLK_NS        5
`define FQH_GLITCH_NS     5
`define FQH_WE_PULSE_NS   35
`define FQH_RD_ACCESS_NS  100
`define FQH_GLITCH_CYC    ((`FQH_GLITCH_NS + `FQH_CLK_NS - 1) / `FQH_CLK_NS)
`define FQH_WE_CYC        ((`FQH_WE_PULSE_NS + `FQH_CLK_NS - 1) / `FQH_CLK_NS)
`define FQH_STB_CYC       ((`FQH_WE_CYC > `FQH_GLITCH_CYC) ? `FQH_WE_CYC : (`FQH_GLITCH_CYC + 1))
`define FQH_RD_CYC        (((`FQH_RD_ACCESS_NS + `FQH_CLK_NS - 1) / `FQH_CLK_NS) + 2)
`define FQH_PWR_GUARD_CYC 64
`define FQH_CNT_W         5
`define FQH_GUARD_W       8

`endif

/* src/fqh_pkg.sv */
// Types for the parallel flash query host.
// Assumes fqh_map.svh supplies the numeric constants.
package fqh_pkg;

    typedef enum logic [1:0]
    {
        FQH_OP_READ,
        FQH_OP_WRITE,
        FQH_OP_QUERY,
        FQH_OP_RESET
    } fqh_op_t;

    typedef enum logic [2:0]
    {
        FQH_ST_IDLE,
        FQH_ST_SETUP,
        FQH_ST_WR,
        FQH_ST_WHOLD,
        FQH_ST_RD,
        FQH_ST_GAP
    } fqh_state_t;

endpackage

/* src/fqh_sync.sv */
// Two-flop synchroniser for the pin inputs of the flash query host.
// Assumes the inputs are asynchronous to i_clk; only o_q may be read downstream.
`timescale 1ns/10ps
`include "fqh_map.svh"

module fqh_sync
(
    input  wire logic                    i_clk,
    input  wire logic                    i_rstn,
    input  wire logic [`FQH_SYNC_W-1:0]  i_d,
    output logic      [`FQH_SYNC_W-1:0]  o_q
);

    logic [`FQH_SYNC_W-1:0] meta_ff;
    logic [`FQH_SYNC_W-1:0] q_ff;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            meta_ff <= '0;
            q_ff    <= '0;
        end
        else
        begin
            meta_ff <= i_d;
            q_ff    <= meta_ff;
        end
    end

    assign o_q = q_ff;

endmodule

/* verif/fqh_ctrl_sva.sv */
// Concurrent checks on the pins and command port of the flash query host.
// Assumes it is bound to fqh_ctrl and sees only that module's ports.
`timescale 1ns/10ps
`include "fqh_map.svh"

module fqh_ctrl_sva
(
    input  wire logic                    i_clk,
    input  wire logic                    i_resetn,
    input  wire logic                    i_supply_ok,
    input  wire logic                    i_req_valid,
    input  wire fqh_pkg::fqh_op_t        i_req_op,
    input  wire logic                    o_req_ready,
    input  wire logic                    o_rd_valid,
    input  wire logic                    o_refused,
    input  wire logic                    o_in_query,
    input  wire logic                    o_ce_n,
    input  wire logic                    o_oe_n,
    input  wire logic                    o_we_n,
    input  wire logic                    o_byte_n,
    input  wire logic [`FQH_ADDR_W-1:0]  o_addr,
    input  wire logic [`FQH_DATA_W-1:0]  o_dq_out,
    input  wire logic                    o_dq_oe
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    // Cycles of good supply; the first few are left to the synchroniser and abort path
    logic [7:0] good_cnt_ff;
    always_ff @(posedge i_clk or negedge i_resetn)
        if (!i_resetn)
            good_cnt_ff <= 8'h00;
        else if (!i_supply_ok)
            good_cnt_ff <= 8'h00;
        else if (good_cnt_ff != 8'hff)
            good_cnt_ff <= good_cnt_ff + 8'h01;

    a_write_strobes: assert property (!o_we_n |-> o_oe_n && !o_ce_n && o_dq_oe)
        else $error("write strobe without chip enable, output disable or data drive");
    a_read_no_drive: assert property (!o_oe_n |-> o_we_n && !o_dq_oe)
        else $error("output enable active while writing or driving data");
    a_we_pulse_len: assert property ($fell(o_we_n) |-> !o_we_n [*7] ##1 o_we_n)
        else $error("write pulse not seven cycles long");
    a_supply_idle: assert property (!i_supply_ok [*4] |-> o_ce_n && o_we_n && o_oe_n && !o_in_query)
        else $error("strobes or query state active under supply lockout");
    a_guard_quiet: assert property (good_cnt_ff > 8'h03 && good_cnt_ff < 8'h40 |-> o_we_n && o_ce_n)
        else $error("strobe activity inside the power-up guard");
    a_query_addr: assert property ($rose(o_we_n) && o_dq_out == `FQH_CMD_QUERY
        |-> o_addr == (o_byte_n ? `FQH_ADDR_QUERY : (`FQH_ADDR_QUERY << 1)))
        else $error("query command written to the wrong address");
    a_query_enter: assert property ($rose(o_in_query)
        |-> $past(o_dq_out, 2) == `FQH_CMD_QUERY && $past(o_we_n) && !$past(o_we_n, 2))
        else $error("query state entered without a query write");
    a_query_exit: assert property ($fell(o_in_query) && i_supply_ok && $past(i_supply_ok, 3)
        |-> $past(o_dq_out, 2) == `FQH_CMD_RESET)
        else $error("query state left without a reset write");
    a_refuse_quiet: assert property (o_refused |-> o_we_n && o_ce_n && $past(o_we_n) && !o_dq_oe)
        else $error("refused query still moved the strobes");
    a_read_answer: assert property (i_req_valid && o_req_ready && i_req_op == fqh_pkg::FQH_OP_READ
        |-> ##24 o_rd_valid)
        else $error("read answer not on cycle 24");
endmodule

/* verif/fqh_flash_model.sv */
// Behavioural parallel flash seen by the query host: command latch, query table, lockout.
// Assumes the bench resolves the shared data bus and drives busy and corrupt.
`timescale 1ns/10ps
`include "fqh_map.svh"

module fqh_flash_model
(
    input  wire logic                    i_supply_ok,
    input  wire logic                    i_busy,
    input  wire logic                    i_corrupt,
    input  wire logic                    i_ce_n,
    input  wire logic                    i_oe_n,
    input  wire logic                    i_we_n,
    input  wire logic                    i_byte_n,
    input  wire logic [`FQH_ADDR_W-1:0]  i_addr,
    input  wire logic [`FQH_DATA_W-1:0]  i_dq,
    output logic      [`FQH_DATA_W-1:0]  o_dq
);
    // Modes: 0 array read, 1 query, 2 autoselect
    logic [1:0]              mode_ff = 2'h0;
    logic                    armed_ff = 1'b0;
    logic [`FQH_ADDR_W-1:0]  cmd_addr_ff;
    logic [`FQH_DATA_W-1:0]  last_ff = 16'h0000;
    realtime                 t_fall;
    wire                     wr_n = i_we_n | i_ce_n;
    wire [`FQH_ADDR_W-1:0]   widx = i_byte_n ? i_addr : (i_addr >> 1);
    wire                     drive = !i_ce_n && !i_oe_n && i_supply_ok;
    wire [`FQH_DATA_W-1:0]   rd_word;

    function automatic logic [15:0] cfi_word(input logic [7:0] idx);
        case (idx)
            8'h10: return 16'h0051;
            8'h11: return 16'h0052;
            8'h12: return 16'h0059;
            8'h13: return 16'h0002;
            8'h15: return 16'h0040;
            8'h1b: return 16'h0027;
            8'h1c: return 16'h0036;
            8'h1f: return 16'h0007;
            8'h20: return 16'h0007;
            8'h21: return 16'h000a;
            8'h23: return 16'h0001;
            8'h24: return 16'h0005;
            8'h25: return 16'h0004;
            8'h27: return 16'h0016;
            8'h28: return 16'h0002;
            8'h2a: return 16'h0005;
            8'h2c: return 16'h0001;
            8'h2d: return 16'h003f;
            8'h30: return 16'h0001;
            8'h40: return 16'h0050;
            8'h41: return 16'h0052;
            8'h42: return 16'h0049;
            default: return 16'h0000;
        endcase
    endfunction

    // Lockout drops any half-written command and falls back to array read
    always @(negedge i_supply_ok)
    begin
        mode_ff = 2'h0;
        armed_ff = 1'b0;
    end

    // A cycle that began without supply stays disarmed, so its rising edge is no command
    always @(negedge wr_n)
    begin
        cmd_addr_ff = widx;
        t_fall = $realtime;
        armed_ff = i_supply_ok;
    end

    always @(posedge wr_n)
    begin
        if (armed_ff && i_supply_ok && i_oe_n && ($realtime - t_fall >= 5.0))
        begin
            if (i_dq[7:0] == 8'hf0)
                mode_ff = 2'h0;
            else if (i_dq[7:0] == 8'h98 && cmd_addr_ff == `FQH_ADDR_QUERY && !i_busy)
                mode_ff = 2'h1;
            else if (i_dq[7:0] == 8'h90)
                mode_ff = 2'h2;
        end
        armed_ff = 1'b0;
    end

    assign rd_word = (mode_ff == 2'h1) ? (cfi_word(widx[7:0]) ^ {15'h0, i_corrupt}) : ~widx[15:0];

    // Released bus shows the inverse of the last word so a stale capture cannot match
    always @(*)
        if (drive)
            last_ff = rd_word;
    assign o_dq = drive ? rd_word : ~last_ff;
endmodule

/* verif/fqh_tb.sv */
// Self-checking bench for the flash query host against a behavioural flash.
// Assumes a 200 MHz clock; all inputs change on the falling edge.
`timescale 1ns/10ps
`include "fqh_map.svh"

module testbench;
    logic                    i_clk, i_resetn, i_supply_ok, i_byte_mode, i_req_valid, busy, corrupt;
    fqh_pkg::fqh_op_t        i_req_op;
    logic [`FQH_ADDR_W-1:0]  i_req_addr;
    logic [`FQH_DATA_W-1:0]  i_req_data;
    logic                    o_req_ready, o_rd_valid, o_refused, o_in_query, o_cfi_mismatch;
    logic                    o_ce_n, o_oe_n, o_we_n, o_byte_n, o_dq_oe;
    logic [`FQH_ADDR_W-1:0]  o_addr;
    logic [`FQH_DATA_W-1:0]  o_rd_data, o_dq_out, flash_dq;
    wire  [`FQH_DATA_W-1:0]  dq_bus = o_dq_oe ? o_dq_out : flash_dq;
    int                      fail_count, checks_done;

    fqh_ctrl uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_supply_ok(i_supply_ok), .i_dev_ready(!busy),
        .i_byte_mode(i_byte_mode), .i_req_valid(i_req_valid), .i_req_op(i_req_op), .i_req_addr(i_req_addr),
        .i_req_data(i_req_data), .i_dq_in(dq_bus), .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data), .o_refused(o_refused), .o_in_query(o_in_query), .o_cfi_mismatch(o_cfi_mismatch),
        .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_byte_n(o_byte_n), .o_addr(o_addr),
        .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe));
    fqh_flash_model u_flash (.i_supply_ok(i_supply_ok), .i_busy(busy), .i_corrupt(corrupt), .i_ce_n(o_ce_n),
        .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_byte_n(o_byte_n), .i_addr(o_addr), .i_dq(dq_bus), .o_dq(flash_dq));

    always #2.5 i_clk = ~i_clk;

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    task automatic chk_flag(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            $display("Error %s expected %b seen %b", name, exp, got);
            fail_count++;
        end
    endtask

    task automatic timed_out(input string what);
        $display("Error %s expected completion seen timeout", what);
        fail_count++;
        print_verdict();
    endtask

    // Holds the request until the edge after ready is seen high, then releases it
    task automatic issue(input fqh_pkg::fqh_op_t op, input logic [21:0] a, input logic [15:0] d);
        int n;
        i_req_op = op;
        i_req_addr = a;
        i_req_data = d;
        i_req_valid = 1'b1;
        n = 0;
        while (!o_req_ready && n < 300)
        begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 300)
            timed_out("request");
        @(negedge i_clk);
        i_req_valid = 1'b0;
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (!o_req_ready && n < 100)
        begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 100)
            timed_out("idle");
    endtask

    task automatic rd(input logic [21:0] a, output logic [15:0] d);
        int n;
        issue(fqh_pkg::FQH_OP_READ, a, 16'h0000);
        n = 0;
        while (!o_rd_valid && n < 60)
        begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 60)
            timed_out("read");
        d = o_rd_data;
    endtask

    task automatic cmd(input fqh_pkg::fqh_op_t op, input logic [21:0] a, input logic [15:0] d);
        issue(op, a, d);
        wait_idle();
    endtask

    // Whole table in word or byte addressing, then back to array reads
    task automatic t_table(input logic bm);
        logic [15:0] d;
        i_byte_mode = bm;
        cmd(fqh_pkg::FQH_OP_QUERY, 22'h0, 16'h0);
        chk_flag("in_query", 1'b1, o_in_query);
        for (int i = 16; i <= 66; i++)
        begin
            if (i > 60 && i < 64)
                continue;
            rd(bm ? 22'(2 * i) : 22'(i), d);
            chk_word("query word", u_flash.cfi_word(8'(i)), d);
        end
        chk_flag("mismatch", 1'b0, o_cfi_mismatch);
        cmd(fqh_pkg::FQH_OP_RESET, 22'h0, 16'h0);
        chk_flag("in_query", 1'b0, o_in_query);
        rd(bm ? 22'h000246 : 22'h000123, d);
        chk_word("array word", 16'hfedc, d);
    endtask

    task automatic t_refuse;
        logic seen;
        busy = 1'b1;
        repeat (4) @(negedge i_clk);
        issue(fqh_pkg::FQH_OP_QUERY, 22'h0, 16'h0);
        seen = 1'b0;
        repeat (5)
        begin
            seen = seen | o_refused;
            @(negedge i_clk);
        end
        chk_flag("refused", 1'b1, seen);
        chk_flag("in_query", 1'b0, o_in_query);
        chk_word("flash mode", 16'h0000, {14'h0, u_flash.mode_ff});
        busy = 1'b0;
        repeat (4) @(negedge i_clk);
        wait_idle();
    endtask

    task automatic t_mismatch;
        logic [15:0] d;
        i_byte_mode = 1'b0;
        corrupt = 1'b1;
        cmd(fqh_pkg::FQH_OP_QUERY, 22'h0, 16'h0);
        rd(22'h000010, d);
        chk_flag("mismatch", 1'b1, o_cfi_mismatch);
        corrupt = 1'b0;
        cmd(fqh_pkg::FQH_OP_QUERY, 22'h0, 16'h0);
        chk_flag("mismatch", 1'b0, o_cfi_mismatch);
        cmd(fqh_pkg::FQH_OP_RESET, 22'h0, 16'h0);
    endtask

    task automatic t_autoselect;
        logic [15:0] d;
        cmd(fqh_pkg::FQH_OP_WRITE, 22'h000555, 16'h0090);
        chk_word("flash mode", 16'h0002, {14'h0, u_flash.mode_ff});
        cmd(fqh_pkg::FQH_OP_QUERY, 22'h0, 16'h0);
        rd(22'h000011, d);
        chk_word("query word", 16'h0052, d);
        cmd(fqh_pkg::FQH_OP_RESET, 22'h0, 16'h0);
        chk_word("flash mode", 16'h0000, {14'h0, u_flash.mode_ff});
    endtask

    task automatic t_supply;
        logic [15:0] d;
        cmd(fqh_pkg::FQH_OP_QUERY, 22'h0, 16'h0);
        i_supply_ok = 1'b0;
        repeat (6) @(negedge i_clk);
        chk_flag("in_query", 1'b0, o_in_query);
        chk_flag("we_n", 1'b1, o_we_n);
        chk_word("flash mode", 16'h0000, {14'h0, u_flash.mode_ff});
        i_supply_ok = 1'b1;
        rd(22'h000010, d);
        chk_word("array word", 16'hffef, d);
    endtask

    initial
    begin
        i_clk = 1'b0;
        i_resetn = 1'b0;
        i_supply_ok = 1'b0;
        busy = 1'b0;
        corrupt = 1'b0;
        i_byte_mode = 1'b0;
        i_req_valid = 1'b0;
        i_req_op = fqh_pkg::FQH_OP_READ;
        i_req_addr = 22'h0;
        i_req_data = 16'h0;
        fail_count = 0;
        checks_done = 0;
        repeat (2) @(negedge i_clk);
        i_resetn = 1'b1;
        repeat (4) @(negedge i_clk);
        i_supply_ok = 1'b1;
        t_table(1'b0);
        t_table(1'b1);
        t_refuse();
        t_mismatch();
        t_autoselect();
        t_supply();
        print_verdict();
    end
endmodule

bind fqh_ctrl fqh_ctrl_sva u_sva (.i_clk(i_clk), .i_resetn(i_resetn), .i_supply_ok(i_supply_ok),
    .i_req_valid(i_req_valid), .i_req_op(i_req_op), .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
    .o_refused(o_refused), .o_in_query(o_in_query), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
    .o_byte_n(o_byte_n), .o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe));
